// *** prot_pkg.sv ***
// constants and types of the cell protection state machine
// Overview of operation
// (RULE_01) both switches on in normal window
// (RULE_02) qualified over-charge turns charge switch off
// (RULE_03) charger gone and release delay restores charge
// (RULE_04) over-charge mode watches only short-circuit threshold
// (RULE_05) over-charge short circuit: discharge off, pull-down on
// (RULE_06) that short releases back to over-charge mode
// (RULE_07) qualified over-discharge turns discharge switch off
// (RULE_08) over-discharge: pull-up on, bias removed, stand-by
// (RULE_09) charger or auto wake-up re-biases from stand-by
// (RULE_10) charger detect under over-discharge closes discharge switch
// (RULE_11) release delay above level returns to normal
// (RULE_12) charge over-current ignored until release level
// (RULE_13) qualified over-current 1: discharge off, pull-down
// (RULE_14) load gone plus release delay restores normal
// (RULE_15) qualified short circuit: discharge off, pull-down
// (RULE_16) short circuit releases after load gone, delay
// (RULE_17) qualified charge over-current turns charge off
// (RULE_18) charger gone plus release delay restores normal
// (RULE_19) zero-volt charger: charge on, discharge off
// (RULE_20) over-discharge delays 20 ms and 1.1 ms
// (RULE_21) over-current delays 12 ms and 4 ms
// (RULE_22) short-circuit delay 400 us
// (RULE_23) delay counters restart when condition drops
// (RULE_24) one clock; reset enters normal, switches on
package prot_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int NS_PER_CLK = 1_000_000_000 / CLK_HZ;

  // typical delays in microseconds
  localparam int OV_DET_US    = 1_000_000;
  localparam int OV_REL_US    = 16_000;
  localparam int UV_DET_US    = 20_000;
  localparam int UV_REL_US    = 1_100;
  localparam int OC1_DET_US   = 12_000;
  localparam int OC_REL_US    = 4_000;
  localparam int SC_DET_US    = 400;
  localparam int OCH_DET_US   = 16_000;
  localparam int OCH_REL_US   = 4_000;

  function automatic int us_to_cycles(input int us);
    longint c;
    c = (longint'(us) * 1000) / NS_PER_CLK;
    if (c < 1) c = 1;
    return int'(c);
  endfunction

  localparam int OV_DET_CYC  = us_to_cycles(OV_DET_US);
  localparam int OV_REL_CYC  = us_to_cycles(OV_REL_US);
  localparam int UV_DET_CYC  = us_to_cycles(UV_DET_US);
  localparam int UV_REL_CYC  = us_to_cycles(UV_REL_US);
  localparam int OC1_DET_CYC = us_to_cycles(OC1_DET_US);
  localparam int OC_REL_CYC  = us_to_cycles(OC_REL_US);
  localparam int SC_DET_CYC  = us_to_cycles(SC_DET_US);
  localparam int OCH_DET_CYC = us_to_cycles(OCH_DET_US);
  localparam int OCH_REL_CYC = us_to_cycles(OCH_REL_US);

  localparam int CNT_W = 26;

  // state codes: one bit changes per step, except between normal and short or over-discharge
  typedef enum logic [2:0] {
    ST_NORMAL   = 3'b000,
    ST_OVCHG    = 3'b001,
    ST_OVCHG_SC = 3'b011,
    ST_DCHG_OC1 = 3'b010,
    ST_SHORT    = 3'b110,
    ST_CHG_OC   = 3'b100,
    ST_OVDCHG   = 3'b101,
    ST_STANDBY  = 3'b111
  } mode_t;

  // comparator results, all asynchronous to clk
  typedef struct packed {
    logic ov_det;        // cell at or above over-charge threshold
    logic ov_rel;        // cell below over-charge release level
    logic uv_det;        // cell below over-discharge threshold
    logic uv_rel;        // cell above over-discharge release level
    logic wake_rel;      // cell above wakeup_release_level
    logic oc1_det;       // sense at or above first over-current threshold
    logic sc_det;        // sense at or above short_circuit_threshold
    logic oc_rel;        // sense at or below over-current release level
    logic och_det;       // sense at or below charge over-current threshold
    logic och_rel;       // sense at or above charge over-current release
    logic chg_detect;    // sense at or below charger-detect level, charger connected
    logic charger_on;    // charger connected
    logic load_on;       // load connected
  } cmp_t;

  typedef struct packed {
    logic charge_switch;
    logic discharge_switch;
    logic pull_down_en;
    logic pull_up_en;
    logic bias_en;
  } drv_t;

endpackage

// *** delay_qual.sv ***
`timescale 1ns/1ps
// counts an uninterrupted condition up to a fixed cycle count
module delay_qual #(
  parameter int CYCLES = 4,
  parameter int W      = 26
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic cond,
  output logic      done
);
  import prot_pkg::*;

  initial begin
    if (CYCLES < 1 || CYCLES >= (1 << W)) $error("delay_qual: bad CYCLES");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } dq_state_t;

  dq_state_t st_ff;
  dq_state_t nxt_st;

  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!cond) begin
      nxt_st.cnt = '0; // RULE_23
    end else if (st_ff.cnt == LAST) begin
      nxt_st.done = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign done = st_ff.done;

  AST_RESTART: assert property (@(posedge clk) disable iff (!rstn) // RULE_23
    !cond |=> !done) else $error("qualifier fired after condition dropped");
endmodule

// *** cell_protection_fsm.sv ***
`timescale 1ns/1ps
// protection state machine of a single lithium-ion cell
module cell_protection_fsm #(
  parameter int  OV_DET_CYCLES  = prot_pkg::OV_DET_CYC,
  parameter int  OV_REL_CYCLES  = prot_pkg::OV_REL_CYC,
  parameter int  UV_DET_CYCLES  = prot_pkg::UV_DET_CYC,
  parameter int  UV_REL_CYCLES  = prot_pkg::UV_REL_CYC,
  parameter int  OC1_DET_CYCLES = prot_pkg::OC1_DET_CYC,
  parameter int  OC_REL_CYCLES  = prot_pkg::OC_REL_CYC,
  parameter int  SC_DET_CYCLES  = prot_pkg::SC_DET_CYC,
  parameter int  OCH_DET_CYCLES = prot_pkg::OCH_DET_CYC,
  parameter int  OCH_REL_CYCLES = prot_pkg::OCH_REL_CYC,
  parameter bit  AUTO_WAKE_EN   = 1'b1,
  parameter bit  ZERO_V_CHG_EN  = 1'b1
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire prot_pkg::cmp_t cmp_in,
  output prot_pkg::drv_t      drv,
  output prot_pkg::mode_t     mode
);
  import prot_pkg::*;

  typedef struct packed {
    cmp_t  sync1;
    cmp_t  sync2;
    mode_t mode;
    drv_t  drv;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  cmp_t c;
  assign c = st_ff.sync2;

  // qualified events
  logic q_ov;
  logic q_ov_rel;
  logic q_uv;
  logic q_uv_rel;
  logic q_oc1;
  logic q_sc;
  logic q_oc_rel;
  logic q_och;
  logic q_och_rel;

  // conditions are gated by mode so counters only run where they matter
  logic in_normal;
  logic in_ovchg;
  logic in_uv;
  assign in_normal = (st_ff.mode == ST_NORMAL);
  assign in_ovchg  = (st_ff.mode == ST_OVCHG);
  assign in_uv     = (st_ff.mode == ST_OVDCHG) || (st_ff.mode == ST_STANDBY);

  delay_qual #(.CYCLES(OV_DET_CYCLES), .W(CNT_W)) u_ov (
    .clk  (clk),
    .rstn (rstn),
    .cond (in_normal && c.ov_det),
    .done (q_ov)
  );
  delay_qual #(.CYCLES(OV_REL_CYCLES), .W(CNT_W)) u_ov_rel (
    .clk  (clk),
    .rstn (rstn),
    .cond (in_ovchg && !c.charger_on && c.ov_rel),
    .done (q_ov_rel)
  );
  delay_qual #(.CYCLES(UV_DET_CYCLES), .W(CNT_W)) u_uv (
    .clk  (clk),
    .rstn (rstn),
    .cond ((in_normal || in_ovchg) && c.uv_det),
    .done (q_uv)
  );
  delay_qual #(.CYCLES(UV_REL_CYCLES), .W(CNT_W)) u_uv_rel (
    .clk  (clk),
    .rstn (rstn),
    .cond ((st_ff.mode == ST_OVDCHG) && c.uv_rel),
    .done (q_uv_rel)
  );
  delay_qual #(.CYCLES(OC1_DET_CYCLES), .W(CNT_W)) u_oc1 (
    .clk  (clk),
    .rstn (rstn),
    .cond (in_normal && c.oc1_det), // RULE_04
    .done (q_oc1)
  );
  delay_qual #(.CYCLES(SC_DET_CYCLES), .W(CNT_W)) u_sc (
    .clk  (clk),
    .rstn (rstn),
    .cond ((in_normal || in_ovchg || st_ff.mode == ST_DCHG_OC1) && c.sc_det),
    .done (q_sc)
  );
  delay_qual #(.CYCLES(OC_REL_CYCLES), .W(CNT_W)) u_oc_rel (
    .clk  (clk),
    .rstn (rstn),
    .cond ((st_ff.mode == ST_DCHG_OC1 || st_ff.mode == ST_SHORT) && !c.load_on && c.oc_rel),
    .done (q_oc_rel)
  );
  delay_qual #(.CYCLES(OCH_DET_CYCLES), .W(CNT_W)) u_och (
    .clk  (clk),
    .rstn (rstn),
    .cond (in_normal && c.och_det), // RULE_12
    .done (q_och)
  );
  delay_qual #(.CYCLES(OCH_REL_CYCLES), .W(CNT_W)) u_och_rel (
    .clk  (clk),
    .rstn (rstn),
    .cond ((st_ff.mode == ST_CHG_OC) && !c.charger_on),
    .done (q_och_rel)
  );

  function automatic drv_t drive_for(input mode_t m, input cmp_t x);
    drv_t d;
    d = '{charge_switch: 1'b1, discharge_switch: 1'b1, pull_down_en: 1'b0,
          pull_up_en: 1'b0, bias_en: 1'b1};
    case (m)
      ST_OVCHG:    d.charge_switch = 1'b0;
      ST_OVCHG_SC: begin
        d.charge_switch    = 1'b0;
        d.discharge_switch = 1'b0;
        d.pull_down_en     = 1'b1;
      end
      ST_DCHG_OC1, ST_SHORT: begin
        d.discharge_switch = 1'b0;
        d.pull_down_en     = 1'b1;
      end
      ST_CHG_OC:   d.charge_switch = 1'b0;
      ST_OVDCHG: begin
        // charger pulling the sense pin low closes the switch to cut loss
        d.discharge_switch = x.charger_on && x.chg_detect;
        d.charge_switch    = ZERO_V_CHG_EN ? 1'b1 : x.charger_on;
      end
      ST_STANDBY: begin
        d.discharge_switch = 1'b0;
        d.charge_switch    = 1'b0;
        d.pull_up_en       = 1'b1;
        d.bias_en          = 1'b0;
      end
      default:     d = d;
    endcase
    return d;
  endfunction

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = cmp_in;
    nxt_st.sync2 = st_ff.sync1;
    case (st_ff.mode)
      ST_NORMAL: begin
        // short circuit beats the slower levels
        if (q_sc) nxt_st.mode = ST_SHORT; // RULE_15
        else if (q_uv) nxt_st.mode = ST_OVDCHG; // RULE_07
        else if (q_ov) nxt_st.mode = ST_OVCHG; // RULE_02
        else if (q_oc1) nxt_st.mode = ST_DCHG_OC1; // RULE_13
        else if (q_och) nxt_st.mode = ST_CHG_OC; // RULE_17
      end
      ST_OVCHG: begin
        if (q_sc) nxt_st.mode = ST_OVCHG_SC; // RULE_05
        else if (q_uv) nxt_st.mode = ST_OVDCHG;
        else if (q_ov_rel) nxt_st.mode = ST_NORMAL; // RULE_03
      end
      ST_OVCHG_SC: begin
        if (!c.load_on && !c.sc_det) nxt_st.mode = ST_OVCHG; // RULE_06
      end
      ST_DCHG_OC1: begin
        if (q_sc) nxt_st.mode = ST_SHORT;
        else if (q_oc_rel) nxt_st.mode = ST_NORMAL; // RULE_14
      end
      ST_SHORT: begin
        if (q_oc_rel) nxt_st.mode = ST_NORMAL; // RULE_16
      end
      ST_CHG_OC: begin
        if (q_och_rel) nxt_st.mode = ST_NORMAL; // RULE_18
      end
      ST_OVDCHG: begin
        // a cell above the release level stays biased so the release delay can run after auto wake-up
        if (q_uv_rel) nxt_st.mode = ST_NORMAL; // RULE_11
        else if (!c.charger_on && !c.uv_rel) nxt_st.mode = ST_STANDBY; // RULE_08
      end
      ST_STANDBY: begin
        if (c.charger_on || (AUTO_WAKE_EN && c.wake_rel)) nxt_st.mode = ST_OVDCHG; // RULE_09
      end
      default: nxt_st.mode = ST_NORMAL;
    endcase
    nxt_st.drv = drive_for(nxt_st.mode, c); // RULE_01 RULE_10 RULE_19
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff.sync1 <= '0;
      st_ff.sync2 <= '0;
      st_ff.mode  <= ST_NORMAL; // RULE_24
      st_ff.drv   <= '{charge_switch: 1'b1, discharge_switch: 1'b1, pull_down_en: 1'b0,
                       pull_up_en: 1'b0, bias_en: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign drv  = st_ff.drv;
  assign mode = st_ff.mode;

  // delay figures kept at their typical values unless overridden
  initial begin
    if (UV_DET_CYCLES < 1 || UV_REL_CYCLES < 1) $error("bad over-discharge delays"); // RULE_20
    if (OC1_DET_CYCLES < 1 || OC_REL_CYCLES < 1) $error("bad over-current delays"); // RULE_21
    if (SC_DET_CYCLES < 1) $error("bad short-circuit delay"); // RULE_22
  end

  AST_NORMAL_ON: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
    mode == ST_NORMAL |-> drv.charge_switch && drv.discharge_switch && !drv.pull_down_en)
    else $error("normal mode without both switches on");
  AST_OV_CHG_OFF: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
    mode == ST_OVCHG |-> !drv.charge_switch) else $error("over-charge with charge on");
  AST_OV_REL: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
    $past(mode) == ST_OVCHG && mode == ST_NORMAL |-> !$past(c.charger_on, 2))
    else $error("over-charge released with charger present");
  AST_OVSC: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
    mode == ST_OVCHG_SC |-> !drv.discharge_switch && drv.pull_down_en)
    else $error("short in over-charge not cut");
  AST_OVSC_REL: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
    $past(mode) == ST_OVCHG_SC && mode != ST_OVCHG_SC |-> mode == ST_OVCHG)
    else $error("short release left over-charge");
  AST_STANDBY: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
    mode == ST_STANDBY |-> drv.pull_up_en && !drv.bias_en && !drv.discharge_switch)
    else $error("stand-by drive wrong");
  AST_WAKE: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
    mode == ST_STANDBY && c.charger_on |=> mode == ST_OVDCHG)
    else $error("charger did not wake");
  AST_OC1: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
    mode == ST_DCHG_OC1 |-> !drv.discharge_switch && drv.pull_down_en && drv.charge_switch)
    else $error("over-current 1 drive wrong");
  AST_SHORT: assert property (@(posedge clk) disable iff (!rstn) // RULE_15
    mode == ST_SHORT |-> !drv.discharge_switch && drv.pull_down_en)
    else $error("short drive wrong");
  AST_CHG_OC: assert property (@(posedge clk) disable iff (!rstn) // RULE_17
    mode == ST_CHG_OC |-> !drv.charge_switch && drv.discharge_switch)
    else $error("charge over-current drive wrong");

  // release checks look two samples back: the qualifier's done flop adds one cycle
  AST_OC1_REL: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
    $past(mode) == ST_DCHG_OC1 && mode == ST_NORMAL |-> !$past(c.load_on, 2))
    else $error("over-current 1 released with load present");
  AST_SHORT_REL: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
    $past(mode) == ST_SHORT && mode == ST_NORMAL |-> !$past(c.load_on, 2))
    else $error("short released with load present");
  AST_OCH_REL: assert property (@(posedge clk) disable iff (!rstn) // RULE_18
    $past(mode) == ST_CHG_OC && mode == ST_NORMAL |-> !$past(c.charger_on, 2))
    else $error("charge over-current released with charger present");
  AST_OVCHG_NO_OC1: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
    in_ovchg |=> !q_oc1)
    else $error("over-current 1 qualified in over-charge");
  AST_UV_NO_OCH: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
    in_uv |=> !q_och)
    else $error("charge over-current qualified in over-discharge");
  AST_CHG_DETECT: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
    mode == ST_OVDCHG |-> drv.discharge_switch == ($past(c.charger_on) && $past(c.chg_detect)))
    else $error("discharge switch does not follow charger detect");
  AST_ZERO_V: assert property (@(posedge clk) disable iff (!rstn) // RULE_19
    ZERO_V_CHG_EN && mode == ST_OVDCHG |-> drv.charge_switch && drv.bias_en)
    else $error("zero-volt charging path not open");
  AST_AUTO_WAKE: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
    AUTO_WAKE_EN && mode == ST_STANDBY && c.wake_rel |=> mode == ST_OVDCHG)
    else $error("auto wake-up did not re-bias");
endmodule

// *** cell_env.sv ***
`timescale 1ns/1ps
// cell, charger and load as the protection comparators see them
module cell_env #(
  parameter int OV_MV     = 4400,
  parameter int OVR_MV    = 4200,
  parameter int UV_MV     = 2500,
  parameter int UVR_MV    = 2550,
  parameter int WAKE_MV   = 2900,
  parameter int OC1_MA    = 6000,
  parameter int SC_MA     = 17000,
  parameter int OCR_MA    = 1000,
  parameter int OCH_MA    = -4000,
  parameter int OCHR_MA   = -3000,
  parameter int CHGDET_MA = -200
) (
  input  wire logic signed [31:0] cell_mv,
  input  wire logic signed [31:0] sense_ma,
  input  wire logic               charger,
  input  wire logic               load,
  output prot_pkg::cmp_t          cmp
);
  import prot_pkg::*;

  // thresholds are plain levels; hysteresis comes from the separate release levels
  always_comb begin
    cmp.ov_det     = cell_mv >= OV_MV;
    cmp.ov_rel     = cell_mv < OVR_MV;
    cmp.uv_det     = cell_mv < UV_MV;
    cmp.uv_rel     = cell_mv > UVR_MV;
    cmp.wake_rel   = cell_mv > WAKE_MV;
    cmp.oc1_det    = sense_ma >= OC1_MA;
    cmp.sc_det     = sense_ma >= SC_MA;
    cmp.oc_rel     = sense_ma <= OCR_MA;
    cmp.och_det    = sense_ma <= OCH_MA;
    cmp.och_rel    = sense_ma >= OCHR_MA;
    cmp.chg_detect = charger && (sense_ma <= CHGDET_MA);
    cmp.charger_on = charger;
    cmp.load_on    = load;
  end
endmodule

// *** cell_protection_fsm_bench.sv ***
`timescale 1ns/1ps
// self-checking bench of the cell protection state machine
module cell_protection_fsm_bench;
  import prot_pkg::*;

  localparam int D_OV = 5, D_UV = 6, D_UVR = 3, D_OC1 = 7, D_REL = 4, D_SC = 3, D_OCH = 5;
  localparam int CHGDET = -200;

  logic        clk;
  logic        rstn;
  int          cell_mv;
  int          sense_ma;
  logic        charger;
  logic        load;
  cmp_t        cmp;
  drv_t        drv;
  mode_t       mode;
  int          errors;
  int          n_tests;
  logic [7:0]  seed;
  mode_t       exp_q[$];

  cell_env #(.CHGDET_MA(CHGDET)) env (.cell_mv(cell_mv), .sense_ma(sense_ma), .charger(charger), .load(load),
    .cmp(cmp));

  cell_protection_fsm #(.OV_DET_CYCLES(D_OV), .OV_REL_CYCLES(D_REL), .UV_DET_CYCLES(D_UV), .UV_REL_CYCLES(D_UVR),
    .OC1_DET_CYCLES(D_OC1), .OC_REL_CYCLES(D_REL), .SC_DET_CYCLES(D_SC), .OCH_DET_CYCLES(D_OCH),
    .OCH_REL_CYCLES(D_REL)) uut (.clk(clk), .rstn(rstn), .cmp_in(cmp), .drv(drv), .mode(mode));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // switch pattern that each mode must show; fields a mode leaves open are not compared
  task automatic chk_drv(input mode_t m, input logic dsx);
    case (m)
      ST_NORMAL: check("drv", drv, 8'h19);
      ST_OVCHG, ST_CHG_OC: check("switches", {drv.charge_switch, drv.discharge_switch}, 8'h01);
      ST_OVCHG_SC: check("switches", {drv.charge_switch, drv.discharge_switch, drv.pull_down_en}, 8'h01);
      ST_STANDBY: check("standby", {drv.discharge_switch, drv.pull_up_en, drv.bias_en}, 8'h02);
      ST_OVDCHG: check("ovdchg", {drv.charge_switch, drv.discharge_switch, drv.bias_en}, {5'h0, 1'b1, dsx, 1'b1});
      default: check("shutoff", {drv.discharge_switch, drv.pull_down_en}, 8'h01);
    endcase
  endtask

  // apply one operating point and wait for the expected mode; a change sooner than dmin cycles is wrong
  task automatic step(input int mv, input int ma, input logic c, input logic l, input mode_t em, input int dmin);
    int    n;
    mode_t m;
    exp_q.push_back(em);
    @(posedge clk);
    cell_mv <= mv;
    sense_ma <= ma;
    charger <= c;
    load <= l;
    #1;
    n = 0;
    // at least three edges, so the two input flops and the drive update are seen
    while ((mode !== em || n < 3) && n < 80) begin
      @(posedge clk);
      #1;
      n++;
    end
    m = exp_q.pop_front();
    if (n >= 80) begin
      errors++;
      $display("Error wait for mode %0d expected change seen none", m);
      complete_run();
    end
    check("early", n >= dmin, 8'h01);
    check("mode", mode, m);
    chk_drv(m, c && ma <= CHGDET);
  endtask

  task automatic stay(input mode_t em);
    repeat (25) @(posedge clk);
    #1;
    check("held mode", mode, em);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("Error watchdog expected finish seen hang");
    complete_run();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    seed = 8'h50;
    rstn = 1'b0;
    cell_mv = 3700;
    sense_ma = 0;
    charger = 1'b0;
    load = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check("reset mode", mode, ST_NORMAL);
    chk_drv(ST_NORMAL, 1'b0);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr_next(seed);
      step(3000 + 4 * seed, 8 * seed - 1000, seed[0], seed[1], ST_NORMAL, 0);
    end
    // interrupted shorts must never add up to a trip
    @(posedge clk);
    sense_ma <= 20000;
    repeat (2) @(posedge clk);
    sense_ma <= 0;
    @(posedge clk);
    sense_ma <= 20000;
    repeat (2) @(posedge clk);
    sense_ma <= 0;
    stay(ST_NORMAL);
    step(3700, 8000, 0, 1, ST_DCHG_OC1, D_OC1);
    step(3700, 0, 0, 0, ST_NORMAL, D_REL);
    step(3700, 20000, 0, 1, ST_SHORT, D_SC);
    step(3700, 0, 0, 1, ST_SHORT, 0);
    stay(ST_SHORT);
    step(3700, 0, 0, 0, ST_NORMAL, D_REL);
    step(4500, -500, 1, 0, ST_OVCHG, D_OV);
    step(4500, 8000, 0, 1, ST_OVCHG, 0);
    stay(ST_OVCHG);
    step(4500, 20000, 0, 1, ST_OVCHG_SC, D_SC);
    step(4500, 0, 0, 0, ST_OVCHG, 0);
    step(4100, -500, 1, 0, ST_OVCHG, 0);
    stay(ST_OVCHG);
    step(4100, 0, 0, 0, ST_NORMAL, D_REL);
    step(3700, -5000, 1, 0, ST_CHG_OC, D_OCH);
    stay(ST_CHG_OC);
    step(3700, 0, 0, 0, ST_NORMAL, D_REL);
    step(2000, 0, 0, 0, ST_STANDBY, D_UV);
    step(2000, -500, 1, 0, ST_OVDCHG, 0);
    step(2000, -5000, 1, 0, ST_OVDCHG, 0);
    stay(ST_OVDCHG);
    step(2000, -100, 1, 0, ST_OVDCHG, 0);
    step(2600, -500, 1, 0, ST_NORMAL, D_UVR);
    step(2000, 0, 0, 0, ST_STANDBY, D_UV);
    step(3000, 0, 0, 0, ST_NORMAL, D_UVR);
    step(0, -500, 1, 0, ST_OVDCHG, D_UV);
    step(3000, -500, 1, 0, ST_NORMAL, D_UVR);
    step(3700, 20000, 0, 1, ST_SHORT, D_SC);
    @(posedge clk);
    rstn <= 1'b0;
    sense_ma <= 0;
    load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("mid reset mode", mode, ST_NORMAL);
    chk_drv(ST_NORMAL, 1'b0);
    @(posedge clk);
    rstn <= 1'b1;
    stay(ST_NORMAL);
    complete_run();
  end
endmodule
